// ===== rtl/pcr_cause_recorder.sv
// Contract
// RL1 - Bit 15: one for ON, zero for WAKE
// RL2 - Bit 11: event came from a GPIO
// RL3 - Bit 10: wake by low threshold, never ON
// RL4 - Bit 7: wake caused by watchdog timer
// RL5 - Bit 6: wake by software clearing sleep bit
// RL6 - Bit 5: event caused by clock alarm
// RL7 - Bit 4: event caused by ON pin
// RL8 - Bit 3: ON after converter undervoltage reset
// RL9 - Bit 2: ON after software reset
// RL10 - Bit 1: ON after hardware reset
// RL11 - Bit 0: ON after watchdog device reset
// RL12 - Flags default zero, cleared by state machine
// RL13 - Off bit 13: internal regulator fault
// RL14 - Off bit 12: power sequence failure
// RL15 - Off bit 11: GPIO requested OFF
// RL16 - Off bit 10: supply below threshold
// RL17 - Off bit 9: over-temperature forced OFF
// RL18 - Off bit 6: software cleared chip-on bit
// RL19 - Off bit 4: ON pin caused OFF
// RL20 - New event clears stale flags of class
// RL21 - Writes ignored, undefined bits read zero
`timescale 1ns/10ps
module pcr_cause_recorder #(
	parameter int unsigned ADDR_W = 16,
	parameter int unsigned DATA_W = 16
) (
	// Clock and reset
	input  wire logic                 mclk_i,
	input  wire logic                 sys_rst_i,
	// Event reports from the main state machine
	input  pcr_pkg::pcr_on_evt_s      on_evt_i,
	input  pcr_pkg::pcr_off_evt_s     off_evt_i,
	// Register port
	input  wire logic [ADDR_W-1:0]    addr_i,
	input  wire logic [DATA_W-1:0]    wdata_i,
	input  wire logic                 wr_i,
	input  wire logic                 rd_i,
	output logic      [DATA_W-1:0]    rdata_o,
	output logic                      rvalid_o,
	// Live copies of both cause registers
	output logic      [15:0]          wake_on_cause_o,
	output logic      [15:0]          shutdown_cause_o
);

	// The decoder compares full 16-bit addresses and returns 16-bit words
	if (ADDR_W < 16 || DATA_W < 16) begin : g_bad_width
		$error("pcr_cause_recorder needs ADDR_W and DATA_W of at least 16");
	end

	logic [15:0]        wake_on_cause_ff;
	logic [15:0]        nxt_wake_on_cause;
	logic [15:0]        shutdown_cause_ff;
	logic [15:0]        nxt_shutdown_cause;
	logic [DATA_W-1:0]  rdata_ff;
	logic [DATA_W-1:0]  nxt_rdata;
	logic               rvalid_ff;
	logic               full_up;

	assign full_up = on_evt_i.full_power_up_flag;

	// Next ON/WAKE cause word; a report in the same cycle as a clear wins,
	// so the newest cause is never lost to a late clear
	always_comb begin
		nxt_wake_on_cause = wake_on_cause_ff;
		// RL12 state machine clear
		if (on_evt_i.clear) begin
			nxt_wake_on_cause = pcr_pkg::PCR_CAUSE_RST;
		end
		if (on_evt_i.valid) begin
			// RL20 drop stale flags
			nxt_wake_on_cause = pcr_pkg::PCR_CAUSE_RST;
			// RL1 ON versus WAKE
			nxt_wake_on_cause[pcr_pkg::ON_FULL_POS] = full_up;
			// RL2 GPIO source
			nxt_wake_on_cause[pcr_pkg::ON_GPIO_POS] = on_evt_i.by_gpio;
			// RL3 low threshold wakes only
			nxt_wake_on_cause[pcr_pkg::ON_LOW_SUP_POS] =
				on_evt_i.wake_by_low_supply & ~full_up;
			// RL4 watchdog wake only
			nxt_wake_on_cause[pcr_pkg::ON_TGUARD_POS] =
				on_evt_i.wake_by_timer_guard & ~full_up;
			// RL5 software wake only
			nxt_wake_on_cause[pcr_pkg::ON_HOST_POS] =
				on_evt_i.wake_by_host_command & ~full_up;
			// RL6 clock alarm source
			nxt_wake_on_cause[pcr_pkg::ON_ALARM_POS] = on_evt_i.up_by_clock_alarm;
			// RL7 ON pin source
			nxt_wake_on_cause[pcr_pkg::ON_PIN_POS] = on_evt_i.up_by_on_pin;
			// RL8 converter droop reset
			nxt_wake_on_cause[pcr_pkg::RST_DROOP_POS] =
				on_evt_i.restart_by_converter_droop & full_up;
			// RL9 software reset
			nxt_wake_on_cause[pcr_pkg::RST_HOST_POS] =
				on_evt_i.restart_by_host_command & full_up;
			// RL10 hardware reset
			nxt_wake_on_cause[pcr_pkg::RST_PIN_POS] =
				on_evt_i.restart_by_pin & full_up;
			// RL11 watchdog device reset
			nxt_wake_on_cause[pcr_pkg::RST_TGUARD_POS] =
				on_evt_i.restart_by_timer_guard & full_up;
		end
	end

	// Next OFF cause word, same set-over-clear priority
	always_comb begin
		nxt_shutdown_cause = shutdown_cause_ff;
		// RL12 state machine clear
		if (off_evt_i.clear) begin
			nxt_shutdown_cause = pcr_pkg::PCR_CAUSE_RST;
		end
		if (off_evt_i.valid) begin
			// RL20 drop stale flags
			nxt_shutdown_cause = pcr_pkg::PCR_CAUSE_RST;
			// RL13 regulator fault
			nxt_shutdown_cause[pcr_pkg::OFF_REG_FAULT_POS] =
				off_evt_i.down_by_internal_regulator_fault;
			// RL14 sequence failure
			nxt_shutdown_cause[pcr_pkg::OFF_SEQ_FAIL_POS] =
				off_evt_i.down_by_sequence_failure;
			// RL15 GPIO request
			nxt_shutdown_cause[pcr_pkg::OFF_GPIO_POS] = off_evt_i.down_by_gpio;
			// RL16 supply threshold
			nxt_shutdown_cause[pcr_pkg::OFF_SUPPLY_POS] =
				off_evt_i.down_by_supply_threshold;
			// RL17 over-temperature
			nxt_shutdown_cause[pcr_pkg::OFF_HEAT_POS] = off_evt_i.down_by_overheat;
			// RL18 software off
			nxt_shutdown_cause[pcr_pkg::OFF_HOST_POS] =
				off_evt_i.down_by_host_command;
			// RL19 ON pin off
			nxt_shutdown_cause[pcr_pkg::OFF_PIN_POS] = off_evt_i.down_by_on_pin;
		end
	end

	// ON/WAKE cause register
	always_ff @(posedge mclk_i) begin
		// RL12 zero after reset
		if (sys_rst_i) begin
			wake_on_cause_ff <= pcr_pkg::PCR_CAUSE_RST;
		end else begin
			wake_on_cause_ff <= nxt_wake_on_cause;
		end
	end

	// OFF cause register
	always_ff @(posedge mclk_i) begin
		// RL12 zero after reset
		if (sys_rst_i) begin
			shutdown_cause_ff <= pcr_pkg::PCR_CAUSE_RST;
		end else begin
			shutdown_cause_ff <= nxt_shutdown_cause;
		end
	end

	// Read decode; an unmapped address answers zero rather than stalling
	always_comb begin
		nxt_rdata = '0;
		// RL21 defined bits only
		if (addr_i[15:0] == pcr_pkg::PCR_ADDR_WAKE_ON_CAUSE && addr_i == ADDR_W'(addr_i[15:0])) begin
			nxt_rdata[15:0] = wake_on_cause_ff & pcr_pkg::PCR_ON_DEFINED;
		end else if (addr_i[15:0] == pcr_pkg::PCR_ADDR_SHUTDOWN_CAUSE
			&& addr_i == ADDR_W'(addr_i[15:0])) begin
			nxt_rdata[15:0] = shutdown_cause_ff & pcr_pkg::PCR_OFF_DEFINED;
		end
	end

	// Read data stands only in the cycle after the strobe
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			rdata_ff  <= '0;
			rvalid_ff <= 1'b0;
		end else begin
			rdata_ff  <= rd_i ? nxt_rdata : '0;
			rvalid_ff <= rd_i;
		end
	end

	// Writes have no path into either register; wdata_i is read by nothing
	// on purpose, both words being owned by the state machine alone
	assign rdata_o          = rdata_ff;
	assign rvalid_o         = rvalid_ff;
	assign wake_on_cause_o  = wake_on_cause_ff;
	assign shutdown_cause_o = shutdown_cause_ff;

	// Checks
	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (sys_rst_i);

	sequence seq_on_report;
		on_evt_i.valid;
	endsequence

	sequence seq_off_report;
		off_evt_i.valid;
	endsequence

	sequence seq_quiet;
		!on_evt_i.valid && !on_evt_i.clear && !off_evt_i.valid && !off_evt_i.clear;
	endsequence

	sequence seq_read;
		rd_i;
	endsequence

	chk_on_kind_flag: // RL1
	assert property (seq_on_report |=> wake_on_cause_ff[15] == $past(full_up))
		else $error("ON/WAKE kind flag does not follow the report");

	chk_on_gpio_flag: // RL2
	assert property (seq_on_report |=> wake_on_cause_ff[11] == $past(on_evt_i.by_gpio))
		else $error("GPIO wake flag wrong");

	chk_low_supply_wake: // RL3
	assert property (wake_on_cause_ff[10] |-> !wake_on_cause_ff[15])
		else $error("low threshold flag shown with a full ON");

	chk_low_supply_set: // RL3
	assert property (seq_on_report ##0 (on_evt_i.wake_by_low_supply && !full_up)
		|=> wake_on_cause_ff[10])
		else $error("low threshold wake not recorded");

	chk_timer_wake: // RL4
	assert property (seq_on_report |=> wake_on_cause_ff[7] ==
		($past(on_evt_i.wake_by_timer_guard) && !$past(full_up)))
		else $error("watchdog wake flag wrong");

	chk_host_wake: // RL5
	assert property (seq_on_report |=> wake_on_cause_ff[6] ==
		($past(on_evt_i.wake_by_host_command) && !$past(full_up)))
		else $error("software wake flag wrong");

	chk_alarm_flag: // RL6
	assert property (seq_on_report |=> wake_on_cause_ff[5] == $past(on_evt_i.up_by_clock_alarm))
		else $error("clock alarm flag wrong");

	chk_on_pin_flag: // RL7
	assert property (seq_on_report |=> wake_on_cause_ff[4] == $past(on_evt_i.up_by_on_pin))
		else $error("ON pin flag wrong");

	chk_restart_only_on: // RL8
	assert property ((|wake_on_cause_ff[3:0]) |-> wake_on_cause_ff[15])
		else $error("reset kind flag shown after a WAKE");

	chk_droop_restart: // RL8
	assert property (seq_on_report ##0 (full_up && on_evt_i.restart_by_converter_droop)
		|=> wake_on_cause_ff[3])
		else $error("converter undervoltage reset not recorded");

	chk_host_restart: // RL9
	assert property (seq_on_report |=> wake_on_cause_ff[2] ==
		($past(on_evt_i.restart_by_host_command) && $past(full_up)))
		else $error("software reset flag wrong");

	chk_pin_restart: // RL10
	assert property (seq_on_report |=> wake_on_cause_ff[1] ==
		($past(on_evt_i.restart_by_pin) && $past(full_up)))
		else $error("hardware reset flag wrong");

	chk_timer_restart: // RL11
	assert property (seq_on_report |=> wake_on_cause_ff[0] ==
		($past(on_evt_i.restart_by_timer_guard) && $past(full_up)))
		else $error("watchdog reset flag wrong");

	chk_reset_zero: // RL12
	assert property (@(posedge mclk_i) disable iff (1'b0)
		sys_rst_i |=> (wake_on_cause_ff == 16'h0000 && shutdown_cause_ff == 16'h0000))
		else $error("cause flags not zero after reset");

	chk_clear_only: // RL12
	assert property ((on_evt_i.clear && !on_evt_i.valid) |=> wake_on_cause_ff == 16'h0000)
		else $error("state machine clear ignored");

	chk_set_beats_clear: // RL12
	assert property ((off_evt_i.clear && off_evt_i.valid && off_evt_i.down_by_overheat)
		|=> shutdown_cause_ff[9])
		else $error("report lost to a clear in the same cycle");

	chk_reg_fault_flag: // RL13
	assert property (seq_off_report |=> shutdown_cause_ff[13] ==
		$past(off_evt_i.down_by_internal_regulator_fault))
		else $error("regulator fault flag wrong");

	chk_seq_fail_flag: // RL14
	assert property (seq_off_report |=> shutdown_cause_ff[12] ==
		$past(off_evt_i.down_by_sequence_failure))
		else $error("sequence failure flag wrong");

	chk_off_gpio_flag: // RL15
	assert property (seq_off_report |=> shutdown_cause_ff[11] == $past(off_evt_i.down_by_gpio))
		else $error("GPIO off flag wrong");

	chk_supply_flag: // RL16
	assert property (seq_off_report |=> shutdown_cause_ff[10] ==
		$past(off_evt_i.down_by_supply_threshold))
		else $error("supply threshold flag wrong");

	chk_heat_flag: // RL17
	assert property (seq_off_report |=> shutdown_cause_ff[9] == $past(off_evt_i.down_by_overheat))
		else $error("over-temperature flag wrong");

	chk_host_off_flag: // RL18
	assert property (seq_off_report |=> shutdown_cause_ff[6] ==
		$past(off_evt_i.down_by_host_command))
		else $error("software off flag wrong");

	chk_pin_off_flag: // RL19
	assert property (seq_off_report |=> shutdown_cause_ff[4] == $past(off_evt_i.down_by_on_pin))
		else $error("ON pin off flag wrong");

	chk_stale_on_dropped: // RL20
	assert property ((seq_on_report ##0 (!full_up && !on_evt_i.by_gpio
		&& !on_evt_i.up_by_clock_alarm && !on_evt_i.up_by_on_pin
		&& !on_evt_i.wake_by_low_supply && !on_evt_i.wake_by_timer_guard
		&& !on_evt_i.wake_by_host_command)) |=> wake_on_cause_ff == 16'h0000)
		else $error("stale ON/WAKE flags kept");

	chk_stale_off_dropped: // RL20
	assert property ((seq_off_report ##0 (off_evt_i.down_by_overheat
		&& !off_evt_i.down_by_on_pin)) |=> shutdown_cause_ff[4] == 1'b0)
		else $error("stale OFF flag kept");

	chk_write_ignored: // RL21
	assert property ((wr_i ##0 seq_quiet) |=> ($stable(wake_on_cause_ff)
		&& $stable(shutdown_cause_ff)))
		else $error("software write changed a cause register");

	chk_undefined_zero: // RL21
	assert property ((wake_on_cause_ff & ~pcr_pkg::PCR_ON_DEFINED) == 16'h0000
		&& (shutdown_cause_ff & ~pcr_pkg::PCR_OFF_DEFINED) == 16'h0000)
		else $error("undefined bit set");

	chk_read_timing: // RL21
	assert property ((rd_i && addr_i[15:0] == pcr_pkg::PCR_ADDR_SHUTDOWN_CAUSE
		&& addr_i == ADDR_W'(addr_i[15:0]))
		|=> (rvalid_o && rdata_o[15:0] == $past(shutdown_cause_ff)) ##1 (!rvalid_o || $past(rd_i)))
		else $error("read answer wrong or late");

	chk_off_clear_only: // RL12
	assert property ((off_evt_i.clear && !off_evt_i.valid) |=> shutdown_cause_ff == 16'h0000)
		else $error("state machine clear of OFF class ignored");

	chk_on_beats_clear: // RL12
	assert property ((seq_on_report ##0 (on_evt_i.clear && on_evt_i.wake_by_low_supply && !full_up))
		|=> wake_on_cause_ff[10])
		else $error("ON/WAKE report lost to a clear in the same cycle");

	chk_kind_mask_on: // RL3
	assert property ((seq_on_report ##0 full_up)
		|=> (wake_on_cause_ff[10] == 1'h0 && wake_on_cause_ff[7:6] == 2'h0))
		else $error("wake-only flag shown with a full ON");

	chk_kind_mask_wake: // RL8
	assert property ((seq_on_report ##0 !full_up) |=> wake_on_cause_ff[3:0] == 4'h0)
		else $error("reset kind flag recorded on a WAKE");

	chk_answer_next: // RL21
	assert property (seq_read |=> rvalid_o)
		else $error("read not answered in the next cycle");

	chk_answer_once: // RL21
	assert property (!rd_i |=> (!rvalid_o && rdata_o == '0))
		else $error("read answer stands too long");

	chk_wake_read: // RL21
	assert property ((seq_read ##0 (addr_i == ADDR_W'(pcr_pkg::PCR_ADDR_WAKE_ON_CAUSE)))
		|=> rdata_o[15:0] == $past(wake_on_cause_ff))
		else $error("wake_on_cause read wrong");

	chk_unmapped_read: // RL21
	assert property ((seq_read ##0 (addr_i != ADDR_W'(pcr_pkg::PCR_ADDR_WAKE_ON_CAUSE)
		&& addr_i != ADDR_W'(pcr_pkg::PCR_ADDR_SHUTDOWN_CAUSE))) |=> rdata_o == '0)
		else $error("unmapped address read not zero");

endmodule

// ===== rtl/pcr_pkg.sv
// Shared constants and carriers of the power event cause recorder
package pcr_pkg;

	// Register addresses on the control port
	localparam logic [15:0] PCR_ADDR_WAKE_ON_CAUSE  = 16'h400E;
	localparam logic [15:0] PCR_ADDR_SHUTDOWN_CAUSE = 16'h400F;

	// Register width and reset value of every cause flag
	localparam int unsigned PCR_REG_W     = 16;
	localparam logic [15:0] PCR_CAUSE_RST = 16'h0000;

	// Field positions of the wake_on_cause register
	localparam int unsigned ON_FULL_POS      = 15;
	localparam int unsigned ON_GPIO_POS      = 11;
	localparam int unsigned ON_LOW_SUP_POS   = 10;
	localparam int unsigned ON_TGUARD_POS    = 7;
	localparam int unsigned ON_HOST_POS      = 6;
	localparam int unsigned ON_ALARM_POS     = 5;
	localparam int unsigned ON_PIN_POS       = 4;
	localparam int unsigned RST_DROOP_POS    = 3;
	localparam int unsigned RST_HOST_POS     = 2;
	localparam int unsigned RST_PIN_POS      = 1;
	localparam int unsigned RST_TGUARD_POS   = 0;

	// Field positions of the shutdown_cause register
	localparam int unsigned OFF_REG_FAULT_POS = 13;
	localparam int unsigned OFF_SEQ_FAIL_POS  = 12;
	localparam int unsigned OFF_GPIO_POS      = 11;
	localparam int unsigned OFF_SUPPLY_POS    = 10;
	localparam int unsigned OFF_HEAT_POS      = 9;
	localparam int unsigned OFF_HOST_POS      = 6;
	localparam int unsigned OFF_PIN_POS       = 4;

	// Bits that exist in each register; the rest read as zero
	localparam logic [15:0] PCR_ON_DEFINED  = 16'h8CFF;
	localparam logic [15:0] PCR_OFF_DEFINED = 16'h3E50;

	// ON or WAKE report from the main state machine
	typedef struct packed {
		logic valid;
		logic clear;
		logic full_power_up_flag;
		logic by_gpio;
		logic wake_by_low_supply;
		logic wake_by_timer_guard;
		logic wake_by_host_command;
		logic up_by_clock_alarm;
		logic up_by_on_pin;
		logic restart_by_converter_droop;
		logic restart_by_host_command;
		logic restart_by_pin;
		logic restart_by_timer_guard;
	} pcr_on_evt_s;

	// OFF report from the main state machine
	typedef struct packed {
		logic valid;
		logic clear;
		logic down_by_internal_regulator_fault;
		logic down_by_sequence_failure;
		logic down_by_gpio;
		logic down_by_supply_threshold;
		logic down_by_overheat;
		logic down_by_host_command;
		logic down_by_on_pin;
	} pcr_off_evt_s;

endpackage

// ===== tb/pcr_cause_recorder_tb.sv
`timescale 1ns/10ps
module pcr_cause_recorder_tb;
	logic                  mclk_i;
	logic                  sys_rst_i;
	pcr_pkg::pcr_on_evt_s  on_evt_i;
	pcr_pkg::pcr_off_evt_s off_evt_i;
	logic [15:0]           addr_i;
	logic [15:0]           wdata_i;
	logic                  wr_i;
	logic                  rd_i;
	logic [15:0]           rdata_o;
	logic                  rvalid_o;
	logic [15:0]           wake_on_cause_o;
	logic [15:0]           shutdown_cause_o;
	int                    fails;
	int                    num_checks;

	pcr_cause_recorder i_dut (
		.mclk_i           (mclk_i),
		.sys_rst_i        (sys_rst_i),
		.on_evt_i         (on_evt_i),
		.off_evt_i        (off_evt_i),
		.addr_i           (addr_i),
		.wdata_i          (wdata_i),
		.wr_i             (wr_i),
		.rd_i             (rd_i),
		.rdata_o          (rdata_o),
		.rvalid_o         (rvalid_o),
		.wake_on_cause_o  (wake_on_cause_o),
		.shutdown_cause_o (shutdown_cause_o)
	);

	// 250 MHz clock
	always #2 mclk_i = ~mclk_i;

	// One compare; a mismatch is counted and printed at once
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			fails++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic finish_test();
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// Cause vector order: gpio, low supply, timer guard, host, alarm, pin, droop..timer restart
	function automatic logic [15:0] on_exp(input logic full, input logic [9:0] c);
		logic [15:0] v;
		v = {full, 3'h0, c[9:8], 2'h0, c[7:0]};
		// Wake-only causes vanish on ON, restart causes on WAKE
		if (full) begin
			v = v & ~16'h04C0;
		end else begin
			v = v & ~16'h000F;
		end
		return v;
	endfunction

	function automatic logic [15:0] off_exp(input logic [6:0] c);
		return {2'h0, c[6:2], 2'h0, c[1], 1'h0, c[0], 4'h0};
	endfunction

	// Report pulses last exactly one cycle; the update is visible after that edge
	task automatic send_on(input logic vld, input logic clr, input logic full, input logic [9:0] c);
		@(posedge mclk_i);
		on_evt_i <= {vld, clr, full, c};
		@(posedge mclk_i);
		on_evt_i <= '0;
		#1;
	endtask

	task automatic send_off(input logic vld, input logic clr, input logic [6:0] c);
		@(posedge mclk_i);
		off_evt_i <= {vld, clr, c};
		@(posedge mclk_i);
		off_evt_i <= '0;
		#1;
	endtask

	task automatic reg_read(input logic [15:0] a, output logic [15:0] d);
		@(posedge mclk_i);
		rd_i   <= 1'h1;
		addr_i <= a;
		@(posedge mclk_i);
		rd_i <= 1'h0;
		#1;
		check("rvalid_o", {15'h0, rvalid_o}, 16'h0001);
		d = rdata_o;
	endtask

	task automatic reg_write(input logic [15:0] a, input logic [15:0] d);
		@(posedge mclk_i);
		wr_i    <= 1'h1;
		addr_i  <= a;
		wdata_i <= d;
		@(posedge mclk_i);
		wr_i <= 1'h0;
	endtask

	// Live copies and register reads must agree with the expectation
	task automatic check_regs(input logic [15:0] eon, input logic [15:0] eoff);
		logic [15:0] d;
		check("wake_on_cause_o", wake_on_cause_o, eon);
		check("shutdown_cause_o", shutdown_cause_o, eoff);
		reg_read(pcr_pkg::PCR_ADDR_WAKE_ON_CAUSE, d);
		check("wake_on_cause", d, eon);
		reg_read(pcr_pkg::PCR_ADDR_SHUTDOWN_CAUSE, d);
		check("shutdown_cause", d, eoff);
	endtask

	task automatic s_defaults();
		logic [15:0] d;
		check_regs(16'h0000, 16'h0000);
		reg_read(16'h4010, d);
		check("unmapped read", d, 16'h0000);
		$display("test defaults done");
	endtask

	// Each single cause in turn, then all at once, for WAKE and for ON
	task automatic s_on_causes();
		for (int k = 0; k < 2; k++) begin
			for (int i = 0; i < 10; i++) begin
				send_on(1'h1, 1'h0, k[0], 10'h001 << i);
				check("on single", wake_on_cause_o, on_exp(k[0], 10'h001 << i));
			end
			send_on(1'h1, 1'h0, k[0], 10'h3FF);
			check_regs(on_exp(k[0], 10'h3FF), 16'h0000);
		end
		$display("test on_causes done");
	endtask

	task automatic s_off_causes();
		for (int i = 0; i < 7; i++) begin
			send_off(1'h1, 1'h0, 7'h01 << i);
			check("off single", shutdown_cause_o, off_exp(7'h01 << i));
		end
		send_off(1'h1, 1'h0, 7'h7F);
		check_regs(on_exp(1'h1, 10'h3FF), 16'h3E50);
		$display("test off_causes done");
	endtask

	// Software writes of ones and zeros leave both registers untouched
	task automatic s_writes();
		reg_write(pcr_pkg::PCR_ADDR_WAKE_ON_CAUSE, 16'h0000);
		reg_write(pcr_pkg::PCR_ADDR_SHUTDOWN_CAUSE, 16'hFFFF);
		reg_write(16'h4010, 16'hFFFF);
		check_regs(16'h883F, 16'h3E50);
		$display("test writes done");
	endtask

	// Clearing is per class; a report in the clearing cycle wins
	task automatic s_clear();
		send_on(1'h0, 1'h1, 1'h0, 10'h000);
		check_regs(16'h0000, 16'h3E50);
		send_on(1'h1, 1'h1, 1'h0, 10'h100);
		send_off(1'h0, 1'h1, 7'h00);
		check_regs(16'h0400, 16'h0000);
		send_off(1'h1, 1'h1, 7'h04);
		check("off report beats clear", shutdown_cause_o, 16'h0200);
		$display("test clear done");
	endtask

	// Back-to-back reads, each answer standing for one cycle only
	task automatic s_b2b_read();
		send_off(1'h1, 1'h0, 7'h10);
		@(posedge mclk_i);
		rd_i   <= 1'h1;
		addr_i <= pcr_pkg::PCR_ADDR_WAKE_ON_CAUSE;
		@(posedge mclk_i);
		addr_i <= pcr_pkg::PCR_ADDR_SHUTDOWN_CAUSE;
		#1;
		check("first read", rdata_o, 16'h0400);
		check("first rvalid", {15'h0, rvalid_o}, 16'h0001);
		@(posedge mclk_i);
		rd_i <= 1'h0;
		#1;
		check("second read", rdata_o, 16'h0800);
		check("second rvalid", {15'h0, rvalid_o}, 16'h0001);
		@(posedge mclk_i);
		#1;
		check("idle rdata", rdata_o, 16'h0000);
		check("idle rvalid", {15'h0, rvalid_o}, 16'h0000);
		$display("test b2b_read done");
	endtask

	// A reset in mid-run returns every flag to zero
	task automatic s_mid_reset();
		send_on(1'h1, 1'h0, 1'h1, 10'h3FF);
		@(posedge mclk_i);
		sys_rst_i <= 1'h1;
		repeat (3) @(posedge mclk_i);
		sys_rst_i <= 1'h0;
		#1;
		check_regs(16'h0000, 16'h0000);
		$display("test mid_reset done");
	endtask

	initial begin
		mclk_i     = 1'h0;
		sys_rst_i  = 1'h1;
		on_evt_i   = '0;
		off_evt_i  = '0;
		addr_i     = 16'h0000;
		wdata_i    = 16'h0000;
		wr_i       = 1'h0;
		rd_i       = 1'h0;
		fails      = 0;
		num_checks = 0;
		repeat (20) @(posedge mclk_i);
		sys_rst_i <= 1'h0;
		s_defaults();
		s_on_causes();
		s_off_causes();
		s_writes();
		s_clear();
		s_b2b_read();
		s_mid_reset();
		finish_test();
	end

	// Guard against a hang; the whole run needs far fewer cycles
	initial begin
		repeat (5000) @(posedge mclk_i);
		fails++;
		$display("ERROR run length expected end seen hang");
		finish_test();
	end
endmodule
